// File: core/clofd_map.vh
// Constants for the core loader and operand fetch sequencer
`ifndef CLOFD_MAP_VH
`define CLOFD_MAP_VH
`define CLOFD_LOAD_LONGS   9'h1f0
`define CLOFD_LAST_LONG    9'h1ef
`define CLOFD_START_PC     9'h000
`define CLOFD_RAM_DEPTH    512
`define CLOFD_AW           9
`define CLOFD_DW           32
`define CLOFD_MAW          16
// Instruction word fields
`define CLOFD_OP_HI        31
`define CLOFD_OP_LO        26
`define CLOFD_WR_BIT       23
`define CLOFD_IMM_BIT      22
`define CLOFD_DST_HI       17
`define CLOFD_DST_LO       9
`define CLOFD_SRC_HI       8
`define CLOFD_SRC_LO       0
// Operation codes
`define CLOFD_OP_MOV       6'h28
`define CLOFD_OP_ADD       6'h20
`define CLOFD_OP_SUB       6'h21
`define CLOFD_OP_AND       6'h18
`define CLOFD_OP_OR        6'h1a
`define CLOFD_OP_XOR       6'h1b
`define CLOFD_OP_JMP       6'h17
`define CLOFD_OP_DJNZ      6'h39
`endif

// File: core/clofd_regram.v
// Core-private register RAM, whole-long access only
`timescale 1ns/10ps
`include "clofd_map.vh"
module clofd_regram (
   // Clock
   input  wire                     core_clk,
   // Read ports
   input  wire [`CLOFD_AW-1:0]     rd_a_addr,
   output wire [`CLOFD_DW-1:0]     rd_a_data,
   input  wire [`CLOFD_AW-1:0]     rd_b_addr,
   output wire [`CLOFD_DW-1:0]     rd_b_data,
   // Write port
   input  wire                     wr_en,
   input  wire [`CLOFD_AW-1:0]     wr_addr,
   input  wire [`CLOFD_DW-1:0]     wr_data
);
   // No reset: longs 0 to 495 are defined by the launch copy, the top 16 are not written by it
   reg [`CLOFD_DW-1:0] mem [0:`CLOFD_RAM_DEPTH-1];
   assign rd_a_data = mem[rd_a_addr];
   assign rd_b_data = mem[rd_b_addr];
   always @(posedge core_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end
endmodule // clofd_regram

// File: core/clofd_alu.v
// Combinational execute unit
`timescale 1ns/10ps
`include "clofd_map.vh"
module clofd_alu (
   // Operation
   input  wire [5:0]               opcode,
   input  wire [`CLOFD_DW-1:0]     dst_val,
   input  wire [`CLOFD_DW-1:0]     src_val,
   // Result
   output reg  [`CLOFD_DW-1:0]     result,
   output reg                      is_branch,
   output reg                      take_branch
);
   always @*
   begin
      result      = dst_val;
      is_branch   = 1'b0;
      take_branch = 1'b0;
      case (opcode)
         `CLOFD_OP_MOV:  result = src_val;
         `CLOFD_OP_ADD:  result = dst_val + src_val;
         `CLOFD_OP_SUB:  result = dst_val - src_val;
         `CLOFD_OP_AND:  result = dst_val & src_val;
         `CLOFD_OP_OR:   result = dst_val | src_val;
         `CLOFD_OP_XOR:  result = dst_val ^ src_val;
         `CLOFD_OP_JMP:
         begin
            is_branch   = 1'b1;
            take_branch = 1'b1;
         end
         `CLOFD_OP_DJNZ:
         begin
            result      = dst_val - 32'h0000_0001;
            is_branch   = 1'b1;
            take_branch = (dst_val != 32'h0000_0001);
         end
         default:        result = dst_val;
      endcase
   end
endmodule // clofd_alu

// File: core/clofd_core.v
// Program loader and fetch-execute sequencer of one core
// How it works
// - Launch copies 496 longs from main memory at the given start address.
// - After copy, special registers are initialised and fetch starts at 0.
// - Register RAM is accessed in whole 32-bit longs only.
// - Register RAM has no port to any other core.
// - Each instruction: read word, resolve operands, execute, optional write.
// - Non-branching instruction advances program address by one.
// - Executed instructions may write any register, code included.
// - Destination field is a 9-bit register address giving the operand.
// - Immediate flag selects literal source, else register address source.
// - Literal source is zero-extended from 9 bits.
// - Arithmetic results go back into the destination register.
// - Branch: immediate jumps to field value, else to register contents.
`timescale 1ns/10ps
`include "clofd_map.vh"
module clofd_core (
   // Clock and reset
   input  wire                     core_clk,
   input  wire                     sys_rst,
   // Launch request
   input  wire                     launch_req,
   input  wire [`CLOFD_MAW-1:0]    launch_addr,
   // Shared main memory read port
   output reg                      mm_rd_req,
   output reg  [`CLOFD_MAW-1:0]    mm_rd_addr,
   input  wire                     mm_rd_ack,
   input  wire [`CLOFD_DW-1:0]     mm_rd_data,
   // Status
   output reg                      loading,
   output reg                      running,
   output reg  [`CLOFD_AW-1:0]     pc,
   output reg                      instr_done,
   output reg                      special_init
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_LOAD  = 3'h1;
   localparam [2:0] ST_INIT  = 3'h2;
   localparam [2:0] ST_FETCH = 3'h3;
   localparam [2:0] ST_EXEC  = 3'h4;

   reg  [2:0]              state;
   reg  [`CLOFD_AW-1:0]    load_idx;
   reg  [`CLOFD_DW-1:0]    instr;
   reg  [2:0]              next_state;
   reg  [`CLOFD_AW-1:0]    next_load_idx;
   reg  [`CLOFD_DW-1:0]    next_instr;
   reg                     next_mm_rd_req;
   reg  [`CLOFD_MAW-1:0]   next_mm_rd_addr;
   reg                     next_loading;
   reg                     next_running;
   reg  [`CLOFD_AW-1:0]    next_pc;
   reg                     next_instr_done;
   reg                     next_special_init;

   // Source operand value: literal or register contents
   function [`CLOFD_DW-1:0] clofd_src_sel;
      input                  imm;
      input [`CLOFD_AW-1:0]  field;
      input [`CLOFD_DW-1:0]  reg_val;
      begin
         if (imm)
            clofd_src_sel = {23'h000000, field};
         else
            clofd_src_sel = reg_val;
      end
   endfunction

   // Operand fields of the held instruction
   wire [5:0]              op_code  = instr[`CLOFD_OP_HI:`CLOFD_OP_LO];
   wire                    imm_flag = instr[`CLOFD_IMM_BIT];
   wire                    wr_flag  = instr[`CLOFD_WR_BIT];
   wire [`CLOFD_AW-1:0]    dst_addr = instr[`CLOFD_DST_HI:`CLOFD_DST_LO];
   wire [`CLOFD_AW-1:0]    src_fld  = instr[`CLOFD_SRC_HI:`CLOFD_SRC_LO];

   // Register RAM ports; port A reads the fetch address or destination
   wire [`CLOFD_AW-1:0]    rd_a_addr = (state == ST_FETCH) ? pc : dst_addr;
   wire [`CLOFD_DW-1:0]    rd_a_data;
   wire [`CLOFD_DW-1:0]    rd_b_data;
   wire [`CLOFD_DW-1:0]    src_val;
   wire [`CLOFD_DW-1:0]    alu_result;
   wire                    is_branch;
   wire                    take_branch;

   assign src_val = clofd_src_sel(imm_flag, src_fld, rd_b_data);

   // Loader writes during the copy, the executing program afterwards
   wire load_wr = (state == ST_LOAD) && mm_rd_req && mm_rd_ack;
   wire exec_wr = (state == ST_EXEC) && wr_flag;
   reg                     ram_we;
   reg  [`CLOFD_AW-1:0]    ram_wa;
   reg  [`CLOFD_DW-1:0]    ram_wd;

   // A single write port: the loader owns it during the copy, so no program
   // write can race a long that is still on its way in
   always @*
   begin
      ram_we = 1'b0;
      ram_wa = dst_addr;
      ram_wd = alu_result;
      case (state)
         ST_LOAD:
         begin
            ram_we = load_wr;
            ram_wa = load_idx;
            ram_wd = mm_rd_data;
         end
         ST_EXEC:
            ram_we = exec_wr;
         default:
            ram_we = 1'b0;
      endcase
   end

   // Private RAM: its only ports are inside this core
   clofd_regram u_ram (
      .core_clk  (core_clk),
      .rd_a_addr (rd_a_addr),
      .rd_a_data (rd_a_data),
      .rd_b_addr (src_fld),
      .rd_b_data (rd_b_data),
      .wr_en     (ram_we),
      .wr_addr   (ram_wa),
      .wr_data   (ram_wd)
   );

   clofd_alu u_alu (
      .opcode      (op_code),
      .dst_val     (rd_a_data),
      .src_val     (src_val),
      .result      (alu_result),
      .is_branch   (is_branch),
      .take_branch (take_branch)
   );

   // Next state
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (launch_req)
               next_state = ST_LOAD;
         ST_LOAD:
            // Execution waits for the final long of the copy
            if (load_wr && load_idx == `CLOFD_LAST_LONG)
               next_state = ST_INIT;
         ST_INIT:  next_state = ST_FETCH;
         ST_FETCH: next_state = ST_EXEC;
         ST_EXEC:  next_state = ST_FETCH;
         default:  next_state = ST_IDLE;
      endcase
   end

   // Read request stands from launch until the last long is answered
   always @*
   begin
      next_mm_rd_req = mm_rd_req;
      case (state)
         ST_IDLE:
            if (launch_req)
               next_mm_rd_req = 1'b1;
         ST_LOAD:
            if (load_wr && load_idx == `CLOFD_LAST_LONG)
               next_mm_rd_req = 1'b0;
         default:
            next_mm_rd_req = 1'b0;
      endcase
   end

   // Start address is captured so the requester may change it later
   always @*
   begin
      next_mm_rd_addr = mm_rd_addr;
      case (state)
         ST_IDLE:
            if (launch_req)
               next_mm_rd_addr = launch_addr;
         ST_LOAD:
            if (load_wr)
               next_mm_rd_addr = mm_rd_addr + 16'h0004;
         default:
            next_mm_rd_addr = mm_rd_addr;
      endcase
   end

   // Copy index doubles as the register address of the incoming long
   always @*
   begin
      next_load_idx = load_idx;
      case (state)
         ST_IDLE:
            if (launch_req)
               next_load_idx = 9'h000;
         ST_LOAD:
            if (load_wr)
               next_load_idx = load_idx + 9'h001;
         default:
            next_load_idx = load_idx;
      endcase
   end

   always @*
   begin
      next_loading = loading;
      case (state)
         ST_IDLE:
            if (launch_req)
               next_loading = 1'b1;
         ST_LOAD:
            if (load_wr && load_idx == `CLOFD_LAST_LONG)
               next_loading = 1'b0;
         default:
            next_loading = 1'b0;
      endcase
   end

   // The fetched word is held while it executes, so a write to its own
   // register takes effect only at its next fetch
   always @*
   begin
      next_instr = instr;
      case (state)
         ST_FETCH:
            next_instr = rd_a_data;
         default:
            next_instr = instr;
      endcase
   end

   always @*
   begin
      next_pc = pc;
      case (state)
         ST_INIT:
            next_pc = `CLOFD_START_PC;
         ST_EXEC:
            if (is_branch && take_branch)
               next_pc = src_val[`CLOFD_AW-1:0];
            else
               next_pc = pc + 9'h001;
         default:
            next_pc = pc;
      endcase
   end

   // Once started the core runs until reset; a new launch is not taken
   always @*
   begin
      next_running = running;
      case (state)
         ST_INIT:
            next_running = 1'b1;
         default:
            next_running = running;
      endcase
   end

   // Special registers are modelled as a one-cycle init pulse
   always @*
   begin
      next_special_init = 1'b0;
      next_instr_done   = 1'b0;
      case (state)
         ST_INIT:
            next_special_init = 1'b1;
         ST_EXEC:
            next_instr_done = 1'b1;
         default:
         begin
            next_special_init = 1'b0;
            next_instr_done   = 1'b0;
         end
      endcase
   end

   // Every register, outputs included, is a flip-flop of its next value
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state        <= ST_IDLE;
         load_idx     <= 9'h000;
         instr        <= 32'h0000_0000;
         mm_rd_req    <= 1'b0;
         mm_rd_addr   <= 16'h0000;
         loading      <= 1'b0;
         running      <= 1'b0;
         pc           <= `CLOFD_START_PC;
         instr_done   <= 1'b0;
         special_init <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         load_idx     <= next_load_idx;
         instr        <= next_instr;
         mm_rd_req    <= next_mm_rd_req;
         mm_rd_addr   <= next_mm_rd_addr;
         loading      <= next_loading;
         running      <= next_running;
         pc           <= next_pc;
         instr_done   <= next_instr_done;
         special_init <= next_special_init;
      end
   end
endmodule // clofd_core

// File: testbench/clofd_core_chk.sv
// Assertions on the core's launch copy and sequencing
`timescale 1ns/10ps
module clofd_core_chk (
   // Clock, reset and launch
   input wire        core_clk,
   input wire        sys_rst,
   input wire        launch_req,
   input wire [15:0] launch_addr,
   // Main memory
   input wire        mm_rd_req,
   input wire [15:0] mm_rd_addr,
   input wire        mm_rd_ack,
   input wire [31:0] mm_rd_data,
   // Status
   input wire        loading,
   input wire        running,
   input wire [8:0]  pc,
   input wire        instr_done,
   input wire        special_init
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_req_in_load: assert property (mm_rd_req |-> loading)
      else $error("req outside copy");
   a_addr_step: assert property (
      mm_rd_req && mm_rd_ack ##1 mm_rd_req |-> mm_rd_addr == $past(mm_rd_addr) + 16'h0004)
      else $error("addr step");
   a_req_stands: assert property (
      mm_rd_req && !mm_rd_ack |=> mm_rd_req && $stable(mm_rd_addr))
      else $error("req dropped");
   a_launch_take: assert property (
      $rose(loading) |-> mm_rd_req && mm_rd_addr == $past(launch_addr) && $past(launch_req))
      else $error("launch addr");
   a_init_after: assert property (
      $fell(loading) |=> special_init && running && pc == 9'h000)
      else $error("init after copy");
   a_no_early_exec: assert property (loading |-> !instr_done && !running)
      else $error("exec during copy");
   a_first_exec: assert property (special_init |=> !instr_done ##1 instr_done)
      else $error("first exec");
   a_exec_pace: assert property (instr_done |=> !instr_done ##1 instr_done)
      else $error("exec pace");
   a_run_holds: assert property (running |=> running)
      else $error("run lost");
   c_stall: cover property (mm_rd_req && !mm_rd_ack);
   c_init: cover property (special_init);
   c_exec: cover property (instr_done);
endmodule // clofd_core_chk
bind clofd_core clofd_core_chk u_chk (
   .core_clk     (core_clk),
   .sys_rst      (sys_rst),
   .launch_req   (launch_req),
   .launch_addr  (launch_addr),
   .mm_rd_req    (mm_rd_req),
   .mm_rd_addr   (mm_rd_addr),
   .mm_rd_ack    (mm_rd_ack),
   .mm_rd_data   (mm_rd_data),
   .loading      (loading),
   .running      (running),
   .pc           (pc),
   .instr_done   (instr_done),
   .special_init (special_init)
);

// File: testbench/clofd_mem_model.sv
// Shared main memory model answering the core's long reads
`timescale 1ns/10ps
module clofd_mem_model (
   // Clock and reset
   input  wire        core_clk,
   input  wire        sys_rst,
   // Long read port
   input  wire        mm_rd_req,
   input  wire [15:0] mm_rd_addr,
   output wire        mm_rd_ack,
   output wire [31:0] mm_rd_data
);
   logic [31:0] mem [0:16383];
   logic [2:0]  cnt;
   logic [31:0] last;
   // Three of eight cycles stall, so the copy meets slow and prompt answers
   assign mm_rd_ack  = mm_rd_req && cnt < 3'h5;
   // Scrambled outside an ack so a stale long never passes for a new one
   assign mm_rd_data = mm_rd_ack ? mem[mm_rd_addr[15:2]] : ~last;
   always @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
      begin
         cnt  <= 3'h0;
         last <= 32'h0;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         if (mm_rd_ack)
            last <= mm_rd_data;
      end
endmodule // clofd_mem_model

// File: testbench/core_loader_operand_fetch_tb_top.sv
// Bench: launch copy, then a program judged by its jump trace
`timescale 1ns/10ps
`include "clofd_map.vh"
module core_loader_operand_fetch_tb_top;
   logic        core_clk, sys_rst, launch_req;
   logic [15:0] launch_addr;
   wire         mm_rd_req, mm_rd_ack, loading, running, instr_done, special_init;
   wire  [15:0] mm_rd_addr;
   wire  [31:0] mm_rd_data;
   wire  [8:0]  pc;
   int          err_total, checked;
   clofd_core u_dut (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .launch_req   (launch_req),
      .launch_addr  (launch_addr),
      .mm_rd_req    (mm_rd_req),
      .mm_rd_addr   (mm_rd_addr),
      .mm_rd_ack    (mm_rd_ack),
      .mm_rd_data   (mm_rd_data),
      .loading      (loading),
      .running      (running),
      .pc           (pc),
      .instr_done   (instr_done),
      .special_init (special_init)
   );
   clofd_mem_model u_mem (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .mm_rd_req  (mm_rd_req),
      .mm_rd_addr (mm_rd_addr),
      .mm_rd_ack  (mm_rd_ack),
      .mm_rd_data (mm_rd_data)
   );
   always #2 core_clk = ~core_clk;
   task automatic results();
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] expv);
      checked++;
      if (seen !== expv)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, expv, seen);
      end
   endtask
   task automatic tmo();
      err_total++;
      results();
   endtask
   function automatic logic [31:0] ins(logic [5:0] op, logic w, logic i, int d, int s);
      ins = {op, 2'b00, w, i, 4'h0, d[8:0], s[8:0]};
   endfunction
   // Results are seen only through the indirect jump, the execution of the copied jump and the DJNZ tests
   task automatic load_prog();
      u_mem.mem[64]     = ins(`CLOFD_OP_ADD, 1, 1, 100, 25);
      u_mem.mem[64+1]   = ins(`CLOFD_OP_ADD, 1, 0, 100, 101);
      u_mem.mem[64+2]   = ins(`CLOFD_OP_JMP, 0, 0, 0, 100);
      u_mem.mem[64+85]  = ins(`CLOFD_OP_JMP, 0, 1, 0, 200);
      u_mem.mem[64+200] = ins(`CLOFD_OP_MOV, 1, 0, 201, 202);
      u_mem.mem[64+201] = ins(`CLOFD_OP_JMP, 0, 1, 0, 400);
      u_mem.mem[64+202] = ins(`CLOFD_OP_JMP, 0, 1, 0, 300);
      u_mem.mem[64+300] = ins(`CLOFD_OP_ADD, 1, 1, 102, 511);
      u_mem.mem[64+301] = ins(`CLOFD_OP_SUB, 1, 1, 102, 510);
      u_mem.mem[64+302] = ins(`CLOFD_OP_DJNZ, 1, 1, 102, 400);
      u_mem.mem[64+303] = ins(`CLOFD_OP_DJNZ, 1, 1, 103, 303);
      u_mem.mem[64+304] = ins(`CLOFD_OP_JMP, 0, 1, 0, 304);
      u_mem.mem[64+100] = 32'h0000_0032;
      u_mem.mem[64+101] = 32'h0000_000a;
      u_mem.mem[64+102] = 32'h0000_0000;
      u_mem.mem[64+103] = 32'h0000_0003;
   endtask
   task automatic t_load();
      int k;
      int n;
      k = 0;
      n = 0;
      @(negedge core_clk);
      launch_req  = 1;
      launch_addr = 16'h0100;
      @(negedge core_clk);
      launch_req = 0;
      while (k < 496)
      begin
         if (++n > 2000)
            tmo();
         chk("loading", loading, 1);
         chk("instr_done", instr_done, 0);
         if (mm_rd_req && mm_rd_ack)
         begin
            chk("mm_rd_addr", mm_rd_addr, 16'h0100 + 4 * k);
            k++;
         end
         @(negedge core_clk);
      end
      chk("mm_rd_req", mm_rd_req, 0);
      @(negedge core_clk);
      chk("special_init", special_init, 1);
      chk("pc", pc, 0);
   endtask
   task automatic t_exec();
      int exp_pc[14] = '{1, 2, 85, 200, 201, 300, 301, 302, 303, 303, 303, 304, 304, 304};
      int n;
      foreach (exp_pc[i])
      begin
         n = 0;
         while (instr_done !== 1'b1)
         begin
            if (++n > 8)
               tmo();
            @(negedge core_clk);
         end
         @(negedge core_clk);
         chk("pc", pc, exp_pc[i]);
      end
   endtask
   task automatic t_refuse();
      launch_req = 1;
      repeat (3) @(negedge core_clk);
      launch_req = 0;
      chk("mm_rd_req", mm_rd_req, 0);
      chk("running", running, 1);
   endtask
   initial
   begin
      core_clk    = 0;
      sys_rst     = 1;
      launch_req  = 0;
      launch_addr = 16'h0000;
      err_total   = 0;
      checked     = 0;
      load_prog();
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 0;
      t_load();
      t_exec();
      t_refuse();
      results();
   end
endmodule // core_loader_operand_fetch_tb_top
